// ---- design/bsc_cfg.svh ----
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH

// ----------------------------------------------------------------------
// Chain geometry
// ----------------------------------------------------------------------
`define BSC_CHAIN_LEN 256
`define BSC_BIDIR_CELLS 3
`define BSC_OUT_CELLS 2

// ----------------------------------------------------------------------
// Test-port signal positions in the synchroniser vector
// ----------------------------------------------------------------------
`define BSC_TS_TCK 0
`define BSC_TS_TDI 1
`define BSC_TS_CAPTURE 2
`define BSC_TS_SHIFT 3
`define BSC_TS_UPDATE 4
`define BSC_TS_MODE 5
`define BSC_TS_W 6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define BSC_BIT_RST 1'b0

`endif

// ---- design/bsc_pkg.sv ----
package bsc_pkg;
    // Cell slot inside a bidirectional group; order gives ctrl the lowest.
    typedef enum logic [1:0] {
        BSC_CTRL,
        BSC_OBS,
        BSC_DATA
    } bsc_slot_t;
endpackage

// ---- design/bsc_chain.sv ----
`timescale 1ns/1ps
`include "bsc_cfg.svh"

module bsc_chain #(
    parameter int N_IN = 2,
    parameter int N_OUT = 2,
    parameter int N_CS = 4,
    parameter int N_BD = 82
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // Test access port side
    input wire logic TCK,
    input wire logic TDI,
    input wire logic CAPTURE_DR,
    input wire logic SHIFT_DR,
    input wire logic UPDATE_DR,
    input wire logic TEST_MODE,
    output logic TDO,
    // Input-only pads
    input wire logic [N_IN-1:0] PAD_IN,
    // Output-only pads
    input wire logic [N_OUT-1:0] CORE_OUT,
    input wire logic [N_OUT-1:0] CORE_OUT_EN,
    output logic [N_OUT-1:0] PAD_OUT,
    output logic [N_OUT-1:0] PAD_OUT_OE,
    // Upper chip-select outputs
    input wire logic [N_CS-1:0] CORE_CS,
    output logic [N_CS-1:0] UPPER_CHIP_SELECT_OUTPUT,
    // Bidirectional pads
    input wire logic [N_BD-1:0] CORE_BD_OUT,
    input wire logic [N_BD-1:0] CORE_BD_OE,
    input wire logic [N_BD-1:0] PAD_BD_IN,
    output logic [N_BD-1:0] PAD_BD_OUT,
    output logic [N_BD-1:0] PAD_BD_OE
);

    localparam int LEN = `BSC_CHAIN_LEN;
    localparam int CS_BASE = `BSC_BIDIR_CELLS * N_BD;
    localparam int OUT_BASE = CS_BASE + N_CS;
    localparam int IN_BASE = OUT_BASE + `BSC_OUT_CELLS * N_OUT;
    localparam int SW = `BSC_TS_W + N_IN + N_BD;

    generate
        if (IN_BASE + N_IN != LEN || N_IN < 1 || N_OUT < 1 || N_CS < 1
            || N_BD < 1) begin : g_bad_counts
            $error("bsc_chain: pin counts must fill the chain exactly");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Synchronisers and test clock edges
    // ------------------------------------------------------------------
    // Every test-port signal crosses in one vector so all see the same
    // edge; the cost is two cycles of latency against a 400 ns clock.
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic tck_d;
    logic [SW-1:0] next_sync1;
    logic [SW-1:0] next_sync2;
    logic next_tck_d;
    logic tck_rise;
    logic tck_fall;
    logic tdi_s;
    logic mode_s;
    logic [N_IN-1:0] in_s;
    logic [N_BD-1:0] bd_in_s;

    always_comb begin
        next_sync1 = {PAD_BD_IN, PAD_IN, TEST_MODE, UPDATE_DR, SHIFT_DR,
                      CAPTURE_DR, TDI, TCK};
        next_sync2 = sync1;
        next_tck_d = sync2[`BSC_TS_TCK];
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync1 <= '0;
            sync2 <= '0;
            tck_d <= `BSC_BIT_RST;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            tck_d <= next_tck_d;
        end
    end

    assign tck_rise = sync2[`BSC_TS_TCK] & ~tck_d;
    assign tck_fall = ~sync2[`BSC_TS_TCK] & tck_d;
    assign tdi_s = sync2[`BSC_TS_TDI];
    assign mode_s = sync2[`BSC_TS_MODE];
    assign in_s = sync2[`BSC_TS_W +: N_IN];
    assign bd_in_s = sync2[`BSC_TS_W + N_IN +: N_BD];

    // ------------------------------------------------------------------
    // Capture map and forced pad values
    // ------------------------------------------------------------------
    logic [LEN-1:0] chain;
    logic [LEN-1:0] upd;
    logic [LEN-1:0] cap;
    logic [N_OUT-1:0] f_out;
    logic [N_OUT-1:0] f_out_oe;
    logic [N_OUT-1:0] out_ctl;
    logic [N_CS-1:0] f_cs;
    logic [N_BD-1:0] f_bd;
    logic [N_BD-1:0] f_bd_oe;

    genvar g;
    generate
        for (g = 0; g < N_BD; g++) begin : g_bd
            localparam int B = `BSC_BIDIR_CELLS * g;
            localparam int D = B + int'(bsc_pkg::BSC_DATA);
            localparam int O = B + int'(bsc_pkg::BSC_OBS);
            localparam int C = B + int'(bsc_pkg::BSC_CTRL);
            assign cap[D] = CORE_BD_OUT[g];
            assign cap[O] = bd_in_s[g];
            assign cap[C] = CORE_BD_OE[g];
            assign f_bd[g] = mode_s ? upd[D] : CORE_BD_OUT[g];
            assign f_bd_oe[g] = mode_s ? upd[C] : CORE_BD_OE[g];
        end
        for (g = 0; g < N_CS; g++) begin : g_cs
            assign cap[CS_BASE + g] = CORE_CS[g];
            assign f_cs[g] = mode_s ? upd[CS_BASE + g] : CORE_CS[g];
        end
        for (g = 0; g < N_OUT; g++) begin : g_out
            localparam int D = OUT_BASE + `BSC_OUT_CELLS * g + 1;
            localparam int C = OUT_BASE + `BSC_OUT_CELLS * g;
            assign cap[D] = CORE_OUT[g];
            assign cap[C] = CORE_OUT_EN[g];
            assign f_out[g] = mode_s ? upd[D] : CORE_OUT[g];
            assign f_out_oe[g] = mode_s ? upd[C] : CORE_OUT_EN[g];
            assign out_ctl[g] = upd[C];
        end
        for (g = 0; g < N_IN; g++) begin : g_in
            assign cap[IN_BASE + g] = in_s[g];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Shift, update and pad registers
    // ------------------------------------------------------------------
    // Capture and shift act on the rising test clock, update and the
    // serial output on the falling one, so the tester samples stable TDO.
    logic [LEN-1:0] next_chain;
    logic [LEN-1:0] next_upd;
    logic next_tdo;

    always_comb begin
        next_chain = chain;
        next_upd = upd;
        next_tdo = TDO;
        if (tck_rise && sync2[`BSC_TS_CAPTURE]) begin
            next_chain = cap;
        end else if (tck_rise && sync2[`BSC_TS_SHIFT]) begin
            next_chain = {tdi_s, chain[LEN-1:1]};
        end
        if (tck_fall && sync2[`BSC_TS_UPDATE]) begin
            next_upd = chain;
        end
        if (tck_fall) begin
            next_tdo = chain[0];
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            chain <= '0;
            upd <= '0;
            TDO <= `BSC_BIT_RST;
            PAD_OUT <= '0;
            PAD_OUT_OE <= '0;
            UPPER_CHIP_SELECT_OUTPUT <= '0;
            PAD_BD_OUT <= '0;
            PAD_BD_OE <= '0;
        end else begin
            chain <= next_chain;
            upd <= next_upd;
            TDO <= next_tdo;
            PAD_OUT <= f_out;
            PAD_OUT_OE <= f_out_oe;
            UPPER_CHIP_SELECT_OUTPUT <= f_cs;
            PAD_BD_OUT <= f_bd;
            PAD_BD_OE <= f_bd_oe;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    AST_SHIFT_LEN: assert property (
        tck_rise && !sync2[`BSC_TS_CAPTURE] && sync2[`BSC_TS_SHIFT]
        |=> chain[LEN-1] == $past(tdi_s)
            && chain[LEN-2:0] == $past(chain[LEN-1:1]))
        else $error("shift did not move the whole chain by one");
    AST_IN_CAPTURE: assert property (
        tck_rise && sync2[`BSC_TS_CAPTURE]
        |=> chain[IN_BASE] == $past(in_s[0]))
        else $error("input cell did not capture the pad");
    AST_OUT_FORCE: assert property (
        mode_s [*2] |-> PAD_OUT[0] == $past(upd[OUT_BASE + 1]))
        else $error("output pad not forced from its data cell");
    // All output pins are checked at once, so a cleared control cell is
    // seen releasing its pad whatever pattern was loaded.
    AST_OUT_HIZ: assert property (
        mode_s |=> PAD_OUT_OE == $past(out_ctl))
        else $error("output control cells did not set the pad drivers");
    AST_BD_FORCE: assert property (
        mode_s |=> PAD_BD_OUT[0] == $past(upd[int'(bsc_pkg::BSC_DATA)]))
        else $error("bidir pad not forced from its data cell");
    AST_BD_OBS: assert property (
        tck_rise && sync2[`BSC_TS_CAPTURE]
        |=> chain[int'(bsc_pkg::BSC_OBS)] == $past(bd_in_s[0]))
        else $error("bidir observe cell missed the pad level");
    AST_BD_DIR: assert property (
        mode_s |=> PAD_BD_OE[0] == $past(upd[int'(bsc_pkg::BSC_CTRL)]))
        else $error("bidir direction not taken from its control cell");
    AST_CS_FORCE: assert property (
        mode_s |=> UPPER_CHIP_SELECT_OUTPUT[0] == $past(upd[CS_BASE]))
        else $error("chip select not forced from its single cell");

endmodule // bsc_chain

// ---- verification/bsc_tap_model.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Test access port controller model
// ---------------------------------------------------------------
// Each step is one test clock period of eight system clocks, 400 ns.
// The test clock stays low between steps, as a real controller leaves it.
module bsc_tap_model (
    // Clock
    input wire logic CLK,
    // Test access port
    input wire logic TDO,
    output logic TCK,
    output logic TDI,
    output logic CAPTURE_DR,
    output logic SHIFT_DR,
    output logic UPDATE_DR
);
    initial begin
        TCK = 1'h0;
        TDI = 1'h0;
        CAPTURE_DR = 1'h0;
        SHIFT_DR = 1'h0;
        UPDATE_DR = 1'h0;
    end

    // Called on a clock edge. Controls lead the rising edge by three
    // cycles and hold until three cycles past the falling edge, which
    // leaves the test clock high for two cycles only. The block reloads
    // TDO three cycles after the fall, so the bit of the step before is
    // taken one cycle into this step, while it stands.
    task automatic step(input logic cap, sh, up, di, output logic seen);
        CAPTURE_DR <= cap;
        SHIFT_DR <= sh;
        UPDATE_DR <= up;
        TDI <= di;
        @(posedge CLK);
        seen = TDO;
        repeat (2) @(posedge CLK);
        TCK <= 1'h1;
        repeat (2) @(posedge CLK);
        TCK <= 1'h0;
        repeat (3) @(posedge CLK);
    endtask
endmodule // bsc_tap_model

// ---- verification/boundary_scan_cell_chain_bench.sv ----
`timescale 1ns/1ps
module boundary_scan_cell_chain_bench;
    localparam int NB = 82;
    logic CLK, SYS_RST, TEST_MODE, TDO, TCK, TDI, t;
    logic CAPTURE_DR, SHIFT_DR, UPDATE_DR;
    logic [1:0] PAD_IN, CORE_OUT, CORE_OUT_EN, PAD_OUT, PAD_OUT_OE;
    logic [3:0] CORE_CS, cs_out;
    logic [NB-1:0] CORE_BD_OUT, CORE_BD_OE, PAD_BD_IN, PAD_BD_OUT;
    logic [NB-1:0] PAD_BD_OE, eo, ee;
    logic [255:0] cap, pat;
    int bad_count = 0;
    int num_checks = 0;
    int i;

    bsc_chain u_bsc_chain (.CLK(CLK), .SYS_RST(SYS_RST), .TCK(TCK),
        .TDI(TDI), .CAPTURE_DR(CAPTURE_DR), .SHIFT_DR(SHIFT_DR),
        .UPDATE_DR(UPDATE_DR), .TEST_MODE(TEST_MODE), .TDO(TDO),
        .PAD_IN(PAD_IN), .CORE_OUT(CORE_OUT), .CORE_OUT_EN(CORE_OUT_EN),
        .PAD_OUT(PAD_OUT), .PAD_OUT_OE(PAD_OUT_OE), .CORE_CS(CORE_CS),
        .UPPER_CHIP_SELECT_OUTPUT(cs_out), .CORE_BD_OUT(CORE_BD_OUT),
        .CORE_BD_OE(CORE_BD_OE), .PAD_BD_IN(PAD_BD_IN),
        .PAD_BD_OUT(PAD_BD_OUT), .PAD_BD_OE(PAD_BD_OE));

    bsc_tap_model u_bsc_tap_model (.CLK(CLK), .TDO(TDO), .TCK(TCK),
        .TDI(TDI), .CAPTURE_DR(CAPTURE_DR), .SHIFT_DR(SHIFT_DR),
        .UPDATE_DR(UPDATE_DR));

    // ---------------------------------------------------------------
    // Checking and closing
    // ---------------------------------------------------------------
    task automatic cmp(input logic [NB-1:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    // Capture, then shift all cells out while a pattern goes in. Each
    // step hands back the bit that the step before it put on TDO.
    task automatic test_capture();
        for (i = 0; i < NB; i++) begin
            cap[3*i] = CORE_BD_OE[i];
            cap[3*i+1] = PAD_BD_IN[i];
            cap[3*i+2] = CORE_BD_OUT[i];
        end
        cap[249:246] = CORE_CS;
        cap[253:250] = {CORE_OUT[1], CORE_OUT_EN[1], CORE_OUT[0],
            CORE_OUT_EN[0]};
        cap[255:254] = PAD_IN;
        u_bsc_tap_model.step(1'h1, 1'h0, 1'h0, 1'h0, t);
        for (i = 0; i < 256; i++) begin
            u_bsc_tap_model.step(1'h0, 1'h1, 1'h0, pat[i], t);
            cmp(NB'(cap[i]), NB'(t));
        end
        $display("test_capture done");
    endtask

    // Update the shifted pattern onto the pads, then hand them back. The
    // update step returns the first pattern bit, which only a chain of
    // exactly 256 cells brings to TDO after 256 shifts.
    task automatic test_update();
        u_bsc_tap_model.step(1'h0, 1'h0, 1'h1, 1'h0, t);
        cmp(NB'(pat[0]), NB'(t));
        TEST_MODE <= 1'h1;
        repeat (5) @(posedge CLK);
        for (i = 0; i < NB; i++) begin
            eo[i] = pat[3*i+2];
            ee[i] = pat[3*i];
        end
        cmp(eo, PAD_BD_OUT);
        cmp(ee, PAD_BD_OE);
        cmp(NB'(pat[249:246]), NB'(cs_out));
        cmp(NB'({pat[253], pat[251]}), NB'(PAD_OUT));
        cmp(NB'({pat[252], pat[250]}), NB'(PAD_OUT_OE));
        TEST_MODE <= 1'h0;
        repeat (5) @(posedge CLK);
        cmp(CORE_BD_OUT, PAD_BD_OUT);
        cmp(CORE_BD_OE, PAD_BD_OE);
        cmp(NB'(CORE_OUT), NB'(PAD_OUT));
        cmp(NB'(CORE_OUT_EN), NB'(PAD_OUT_OE));
        cmp(NB'(CORE_CS), NB'(cs_out));
        $display("test_update done");
    endtask

    initial begin
        CLK = 1'h0;
        forever #25 CLK = ~CLK;
    end

    initial begin
        #1000000;
        bad_count++;
        complete_run();
    end

    initial begin
        SYS_RST = 1'h1;
        TEST_MODE = 1'h0;
        PAD_IN = 2'h1;
        CORE_OUT = 2'h1;
        CORE_OUT_EN = 2'h2;
        CORE_CS = 4'hA;
        for (i = 0; i < NB; i++) begin
            CORE_BD_OUT[i] = i[0];
            CORE_BD_OE[i] = (i % 3 == 0);
            PAD_BD_IN[i] = (i % 5 < 2);
        end
        for (i = 0; i < 256; i++) pat[i] = i[0] ^ i[2] ^ i[5];
        repeat (5) @(posedge CLK);
        SYS_RST <= 1'h0;
        @(posedge CLK);
        test_capture();
        test_update();
        complete_run();
    end
endmodule // boundary_scan_cell_chain_bench
